/* hw/tspp_port_unit.sv */
// Timed pin port unit: five overlapping ports, six clock blocks, APB registers.
//
// Contract
// [R1] Ports of width 1, 4, 8, 16, 32.
// [R2] One direction for all pins of a port.
// [R3] Drive pins, or sample with optional condition.
// [R4] Register access completes in one bus access.
// [R5] Open collector: zero pulls low, one floats.
// [R6] Open collector chosen per port.
// [R7] Data passes transfer register and shift stage; input data goes from the pins straight to the transfer register.
// [R8] 16-bit counter schedules each transfer; here only a port with its timed bit set waits for the count.
// [R9] Counter readable; transfer may wait for count.
// [R10] Counter captured as timestamp on transfer.
// [R11] Enabled link removes ports from its pins.
// [R12] Narrower enabled port beats wider on pins.
// [R13] Unshared pins stay with the wider port.
// [R14] Ports keep nominal width when pins lost.
// [R15] Six clock blocks; block zero is reference.
// [R16] Other blocks run at programmable rates.
// [R17] Block may take 1-bit port, divided.
// [R18] Ready-in strobe accepted; ready-out strobe produced.
// [R19] After reset every port uses block zero.
// [R20] Pin conditions raise events, not interrupts.
// [R21] Pull-downs enabled on all pins in reset.
// [R22] Counter steps on each attached clock tick; here it steps only while the port is enabled.
// [R23] Conditional input waits for equal or unequal.
//
// The APB interface to the registers and the address map are this design's own decisions.
`timescale 1ns/1ps

`include "tspp_map.svh"

module tspp_port_unit import tspp_pkg::*; (
	// Clock and reset.
	input  wire logic        clk_i,
	input  wire logic        sys_rst_i,
	// APB slave.
	input  wire logic        psel_i,
	input  wire logic        penable_i,
	input  wire logic        pwrite_i,
	input  wire logic [11:0] paddr_i,
	input  wire logic [31:0] pwdata_i,
	output logic             pready_o,
	output logic      [31:0] prdata_o,
	output logic             pslverr_o,
	// Pin bank.
	input  wire logic [31:0] pin_i,
	output logic      [31:0] pin_o,
	output logic      [31:0] pin_oe_o,
	output logic      [31:0] pin_pd_o,
	// Strobes, one per port.
	input  wire logic [4:0]  ready_in_i,
	output logic      [4:0]  outgoing_strobe_o,
	// Events to the scheduler, one per port.
	output logic      [4:0]  port_event_o
);

	// ************************************************************
	// Input synchronisers
	// ************************************************************
	logic [31:0] pin_s1;
	logic [31:0] pin_s2;
	logic [4:0]  rdy_s1;
	logic [4:0]  rdy_s2;
	logic        src_d3;

	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			pin_s1 <= 32'h0000_0000;
			pin_s2 <= 32'h0000_0000;
			rdy_s1 <= 5'h00;
			rdy_s2 <= 5'h00;
			src_d3 <= 1'b0;
		end else begin
			pin_s1 <= pin_i;
			pin_s2 <= pin_s1;
			rdy_s1 <= ready_in_i;
			rdy_s2 <= rdy_s1;
			src_d3 <= pin_s2[0];
		end
	end

	// Rising edge on the 1-bit port's pin, a clock block source.
	logic src_edge;
	assign src_edge = pin_s2[0] & ~src_d3;

	// ************************************************************
	// Bus decode
	// ************************************************************
	logic       bus_setup;
	logic       bus_wr;
	logic       bus_rd;
	logic       glb_sel;
	logic [5:0] glb_idx;
	logic [2:0] port_idx;
	logic [2:0] reg_idx;

	assign bus_setup = psel_i & ~penable_i;
	assign bus_wr    = psel_i & penable_i & pready_o & pwrite_i;
	assign bus_rd    = psel_i & penable_i & pready_o & ~pwrite_i;
	assign glb_sel   = paddr_i[`TSPP_GLB_BIT];
	assign glb_idx   = paddr_i[7:2];
	assign port_idx  = paddr_i[7:5];
	assign reg_idx   = paddr_i[4:2];

	// ************************************************************
	// Link enable
	// ************************************************************
	logic link_en;

	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			link_en <= 1'b0;
		end else if (bus_wr && glb_sel && glb_idx == `TSPP_R_LINK) begin
			link_en <= pwdata_i[0];
		end
	end

	// ************************************************************
	// Clock blocks
	// ************************************************************
	logic [`TSPP_NCB-1:0] cb_tick;
	tspp_cb_t             cb_cfg [`TSPP_NCB];

	// Block zero is the reference clock: a tick on every cycle.
	assign cb_tick[0] = 1'b1; // [R15]
	assign cb_cfg[0]  = `TSPP_CB_RST;

	genvar k;
	generate
		for (k = 1; k < `TSPP_NCB; k++) begin : g_cb
			tspp_cb_t   cfg;
			logic [7:0] div_cnt;
			logic       src_ev;
			logic       tick;

			assign src_ev     = cfg.src_pin ? src_edge : 1'b1; // [R17]
			assign cb_tick[k] = tick;
			assign cb_cfg[k]  = cfg;

			always_ff @(posedge clk_i or posedge sys_rst_i) begin
				if (sys_rst_i) begin
					cfg <= `TSPP_CB_RST;
				end else if (bus_wr && glb_sel && glb_idx == `TSPP_R_CB0 + 6'(k)) begin
					cfg <= tspp_cb_t'(pwdata_i[`TSPP_CB_W-1:0]); // [R16]
				end
			end

			// Divide the source by div+1.
			always_ff @(posedge clk_i or posedge sys_rst_i) begin
				if (sys_rst_i) begin
					div_cnt <= 8'h00;
					tick    <= 1'b0;
				end else if (src_ev) begin
					tick    <= (div_cnt == cfg.div); // [R16]
					div_cnt <= (div_cnt == cfg.div) ? 8'h00 : div_cnt + 8'h01;
				end else begin
					tick    <= 1'b0;
				end
			end
		end
	endgenerate

	// ************************************************************
	// Ports
	// ************************************************************
	logic [31:0]           port_out [`TSPP_NPORT];
	logic [31:0]           port_rd  [`TSPP_NPORT];
	logic [`TSPP_NPORT-1:0] port_en;
	logic [`TSPP_NPORT-1:0] port_dir;
	logic [`TSPP_NPORT-1:0] port_oc;
	logic [`TSPP_NPORT-1:0] port_ev;

	genvar j;
	generate
		for (j = 0; j < `TSPP_NPORT; j++) begin : g_port
			localparam int W = tspp_width(j); // [R1]
			tspp_ctrl_t ctrl;
			logic [W-1:0] xfer;
			logic [W-1:0] shreg;
			logic [W-1:0] cond;
			logic [W-1:0] sample;
			logic [15:0]  cnt;
			logic [15:0]  tmr;
			logic [15:0]  stamp;
			logic         valid;
			logic         hit;
			logic         tick;
			logic         time_ok;
			logic         cond_ok;
			logic         stb_ok;
			logic         fire;
			logic         take;
			logic         stb_d;

			assign hit    = ~glb_sel && port_idx == 3'(j);
			// Unknown clock block codes stop the port.
			assign tick   = (ctrl.clk_sel < 3'(`TSPP_NCB)) ? cb_tick[ctrl.clk_sel] : 1'b0; // [R22]
			// The port samples its full width even if it lost pins.
			assign sample = pin_s2[W-1:0]; // [R14]
			assign time_ok = ~ctrl.timed | (cnt == tmr); // [R9]
			assign cond_ok = ~ctrl.cond_en | ((sample == cond) ^ ctrl.cond_ne); // [R23]
			assign stb_ok  = ~ctrl.strobe_en | rdy_s2[j]; // [R18]
			assign fire = ctrl.enable & ctrl.dir_out & valid & tick & time_ok; // [R8]
			assign take = ctrl.enable & ~ctrl.dir_out & ~valid & tick & time_ok & cond_ok & stb_ok; // [R3]

			// Control and setup registers.
			always_ff @(posedge clk_i or posedge sys_rst_i) begin
				if (sys_rst_i) begin
					ctrl <= `TSPP_CTRL_RST; // [R19]
					tmr  <= 16'h0000;
					cond <= '0;
				end else if (bus_wr && hit) begin
					case (reg_idx)
						`TSPP_R_CTRL: ctrl <= tspp_ctrl_t'(pwdata_i[`TSPP_CTRL_W-1:0]); // [R6]
						`TSPP_R_TIME: tmr  <= pwdata_i[15:0];
						`TSPP_R_COND: cond <= pwdata_i[W-1:0];
						default: ;
					endcase
				end
			end

			// Port counter.
			always_ff @(posedge clk_i or posedge sys_rst_i) begin
				if (sys_rst_i) begin
					cnt <= 16'h0000;
				end else if (ctrl.enable && tick) begin
					cnt <= cnt + 16'h0001; // [R22]
				end
			end

			// Transfer register, shift stage and timestamp.
			always_ff @(posedge clk_i or posedge sys_rst_i) begin
				if (sys_rst_i) begin
					xfer  <= '0;
					shreg <= '0;
					stamp <= 16'h0000;
					valid <= 1'b0;
				end else begin
					if (fire) begin
						shreg <= xfer; // [R7]
						stamp <= cnt; // [R10]
					end
					if (take) begin
						xfer  <= sample; // [R7]
						stamp <= cnt; // [R10]
					end
					// A new transfer wins over the access that empties the register.
					if (bus_wr && hit && reg_idx == `TSPP_R_DATA && ctrl.dir_out) begin
						xfer  <= pwdata_i[W-1:0];
						valid <= 1'b1;
					end else if (take) begin
						valid <= 1'b1;
					end else if (fire || (bus_rd && hit && reg_idx == `TSPP_R_DATA && !ctrl.dir_out)) begin
						valid <= 1'b0;
					end
				end
			end

			// Strobe beside output data and scheduler event.
			always_ff @(posedge clk_i or posedge sys_rst_i) begin
				if (sys_rst_i) begin
					stb_d                <= 1'b0;
					outgoing_strobe_o[j] <= 1'b0;
					port_event_o[j]      <= 1'b0;
				end else begin
					// The pins follow one cycle after a fire, so the strobe waits a cycle to stand beside them.
					stb_d                <= fire & ctrl.strobe_en;
					outgoing_strobe_o[j] <= stb_d; // [R18]
					port_event_o[j]      <= ctrl.enable & (ctrl.dir_out ? ~valid : valid); // [R20]
				end
			end

			always_comb begin
				port_rd[j] = 32'h0000_0000;
				case (reg_idx)
					`TSPP_R_CTRL:  port_rd[j][`TSPP_CTRL_W-1:0] = ctrl;
					`TSPP_R_DATA:  port_rd[j][W-1:0] = xfer;
					`TSPP_R_TIME:  port_rd[j][15:0] = tmr;
					`TSPP_R_COND:  port_rd[j][W-1:0] = cond;
					`TSPP_R_COUNT: port_rd[j][15:0] = cnt; // [R9]
					`TSPP_R_STAMP: port_rd[j][15:0] = stamp; // [R10]
					`TSPP_R_STAT:  port_rd[j][0] = valid;
					default: ;
				endcase
			end

			assign port_out[j] = 32'(shreg);
			assign port_en[j]  = ctrl.enable;
			assign port_dir[j] = ctrl.dir_out; // [R2]
			assign port_oc[j]  = ctrl.oc;
			assign port_ev[j]  = port_event_o[j];
		end
	endgenerate

	// ************************************************************
	// Pin ownership and drive
	// ************************************************************
	logic [31:0] next_pin_o;
	logic [31:0] next_pin_oe;

	genvar p;
	generate
		for (p = 0; p < `TSPP_NPIN; p++) begin : g_pin
			logic [2:0] own;
			logic       owned;

			// Narrowest enabled port covering the pin takes it.
			always_comb begin
				own   = 3'h0;
				owned = 1'b0;
				for (int q = `TSPP_NPORT - 1; q >= 0; q--) begin
					if (port_en[q] && p < tspp_width(q)) begin
						own   = 3'(q); // [R12]
						owned = 1'b1; // [R13]
					end
				end
				if (link_en && p >= `TSPP_LINK_LO && p <= `TSPP_LINK_HI) begin
					owned = 1'b0; // [R11]
				end
			end

			always_comb begin
				next_pin_o[p]  = 1'b0;
				next_pin_oe[p] = 1'b0;
				if (owned && port_dir[own]) begin
					if (port_oc[own]) begin
						next_pin_oe[p] = ~port_out[own][p]; // [R5]
					end else begin
						next_pin_o[p]  = port_out[own][p];
						next_pin_oe[p] = 1'b1;
					end
				end
			end
		end
	endgenerate

	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			pin_o    <= 32'h0000_0000;
			pin_oe_o <= 32'h0000_0000;
			pin_pd_o <= `TSPP_PD_RST; // [R21]
		end else begin
			pin_o    <= next_pin_o;
			pin_oe_o <= next_pin_oe;
			pin_pd_o <= ~next_pin_oe;
		end
	end

	// ************************************************************
	// APB answer
	// ************************************************************
	logic [31:0] next_rdata;
	logic        next_hit;

	always_comb begin
		next_rdata = 32'h0000_0000;
		next_hit   = 1'b0;
		if (glb_sel) begin
			if (glb_idx == `TSPP_R_LINK) begin
				next_rdata[0] = link_en;
				next_hit      = 1'b1;
			end else if (glb_idx == `TSPP_R_EVENTS) begin
				next_rdata[`TSPP_NPORT-1:0] = port_ev;
				next_hit                    = 1'b1;
			end else if (glb_idx >= `TSPP_R_CB0 && glb_idx < `TSPP_R_CB0 + 6'(`TSPP_NCB)) begin
				next_rdata[`TSPP_CB_W-1:0] = cb_cfg[3'(glb_idx - `TSPP_R_CB0)];
				next_hit                   = 1'b1;
			end
		end else if (port_idx < 3'(`TSPP_NPORT) && reg_idx <= `TSPP_R_STAT) begin
			next_rdata = port_rd[port_idx];
			next_hit   = 1'b1;
		end
	end

	// One wait-free access: ready in the access phase after every setup.
	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			pready_o  <= 1'b0;
			prdata_o  <= 32'h0000_0000;
			pslverr_o <= 1'b0;
		end else begin
			pready_o  <= bus_setup; // [R4]
			pslverr_o <= bus_setup & ~next_hit;
			if (bus_setup) begin
				prdata_o <= next_rdata;
			end
		end
	end

endmodule

/* hw/tspp_map.svh */
// Register offsets, reset values and fixed counts of the timed pin port unit.
`ifndef TSPP_MAP_SVH
`define TSPP_MAP_SVH

// Number of ports and clock blocks.
`define TSPP_NPORT      5
`define TSPP_NCB        6
`define TSPP_NPIN       32
// Pins taken over by the inter-chip link when it is enabled.
`define TSPP_LINK_LO    24
`define TSPP_LINK_HI    31

// Address bit that selects the global window over the port windows.
`define TSPP_GLB_BIT    8
// Port registers, word index within a 32-byte port window.
`define TSPP_R_CTRL     3'h0
`define TSPP_R_DATA     3'h1
`define TSPP_R_TIME     3'h2
`define TSPP_R_COND     3'h3
`define TSPP_R_COUNT    3'h4
`define TSPP_R_STAMP    3'h5
`define TSPP_R_STAT     3'h6
// Global registers, word index within the global window.
`define TSPP_R_LINK     6'h00
`define TSPP_R_EVENTS   6'h01
`define TSPP_R_CB0      6'h10

// Field widths and reset values.
`define TSPP_CTRL_W     10
`define TSPP_CB_W       9
`define TSPP_CTRL_RST   10'h000
`define TSPP_CB_RST     9'h000
`define TSPP_PD_RST     32'hFFFF_FFFF

`endif

/* hw/tspp_pkg.sv */
// Types shared by the timed pin port unit.
package tspp_pkg;

	// Port control word; clk_sel picks the clock block driving the port.
	typedef struct packed {
		logic [2:0] clk_sel;
		logic       strobe_en;
		logic       timed;
		logic       cond_ne;
		logic       cond_en;
		logic       oc;
		logic       dir_out;
		logic       enable;
	} tspp_ctrl_t;

	// Clock block setup: source is the port 0 pin when src_pin is set.
	typedef struct packed {
		logic       src_pin;
		logic [7:0] div;
	} tspp_cb_t;

	// Nominal width of each port, narrowest first.
	function automatic int tspp_width(input int idx);
		case (idx)
			0: return 1;
			1: return 4;
			2: return 8;
			3: return 16;
			default: return 32;
		endcase
	endfunction

endpackage

/* verif/tspp_port_unit_props.sv */
// Checker for bus timing, pull-downs and strobes of the timed pin port unit.
`timescale 1ns/1ps
module tspp_port_unit_props (
	// Clock and reset.
	input wire logic        clk_i,
	input wire logic        sys_rst_i,
	// APB slave.
	input wire logic        psel_i,
	input wire logic        penable_i,
	input wire logic        pwrite_i,
	input wire logic [11:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	input wire logic        pready_o,
	input wire logic [31:0] prdata_o,
	input wire logic        pslverr_o,
	// Pins, strobes and events.
	input wire logic [31:0] pin_i,
	input wire logic [31:0] pin_o,
	input wire logic [31:0] pin_oe_o,
	input wire logic [31:0] pin_pd_o,
	input wire logic [4:0]  ready_in_i,
	input wire logic [4:0]  outgoing_strobe_o,
	input wire logic [4:0]  port_event_o
);
	// ********************************
	// Properties
	// ********************************
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (sys_rst_i);
	wire setup = psel_i && !penable_i;
	property p_ack_after_setup; setup |=> pready_o; endproperty
	a_ack_after_setup: assert property (p_ack_after_setup) else $error("no ready after setup");
	property p_ack_cause; pready_o |-> $past(setup); endproperty
	a_ack_cause: assert property (p_ack_cause) else $error("ready without setup");
	property p_ack_single; pready_o |=> !pready_o; endproperty
	a_ack_single: assert property (p_ack_single) else $error("ready longer than one cycle");
	property p_err_zero; pslverr_o |-> pready_o && prdata_o == 32'h0000_0000; endproperty
	a_err_zero: assert property (p_err_zero) else $error("error without ready or zero data");
	property p_rdata_hold; !setup |=> $stable(prdata_o); endproperty
	a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved outside setup");
	property p_pd_in_reset; $fell(sys_rst_i) |-> pin_pd_o == 32'hFFFF_FFFF; endproperty
	a_pd_in_reset: assert property (p_pd_in_reset) else $error("pull-downs off in reset");
	property p_pd_off_driven; (pin_pd_o & pin_oe_o & $past(pin_oe_o)) == 32'h0000_0000; endproperty
	a_pd_off_driven: assert property (p_pd_off_driven) else $error("pull-down on a driven pin");
	property p_strobe_pulse; (outgoing_strobe_o & $past(outgoing_strobe_o)) == 5'h00; endproperty
	a_strobe_pulse: assert property (p_strobe_pulse) else $error("strobe longer than one cycle");
	c_err: cover property (pslverr_o);
	c_strobe: cover property (|outgoing_strobe_o);
	c_event: cover property (|port_event_o);
endmodule

bind tspp_port_unit tspp_port_unit_props u_props (.clk_i, .sys_rst_i, .psel_i, .penable_i, .pwrite_i,
	.paddr_i, .pwdata_i, .pready_o, .prdata_o, .pslverr_o, .pin_i, .pin_o, .pin_oe_o, .pin_pd_o,
	.ready_in_i, .outgoing_strobe_o, .port_event_o);

/* verif/tspp_pin_model.sv */
// Model of the external hardware sitting on the general-purpose pins.
`timescale 1ns/1ps
module tspp_pin_model (
	// Clock.
	input  wire logic        clk_i,
	// Unit side of the pins.
	input  wire logic [31:0] drv_i,
	input  wire logic [31:0] drv_en_i,
	input  wire logic [31:0] pd_en_i,
	// Outside driver.
	input  wire logic [31:0] ext_val_i,
	input  wire logic [31:0] ext_en_i,
	input  wire logic [4:0]  rdy_i,
	output logic      [31:0] level_o,
	output logic      [4:0]  ready_o
);
	// ********************************
	// Wire resolution
	// ********************************
	logic [31:0] tog = 32'h0000_0000;
	// A floating pin with no pull shows a level that flips every cycle.
	always @(posedge clk_i) tog <= ~tog;
	always_comb level_o = (drv_en_i & drv_i) | (~drv_en_i & ext_en_i & ext_val_i)
		| (~drv_en_i & ~ext_en_i & ~pd_en_i & tog);
	always_comb ready_o = rdy_i;
endmodule

/* verif/testbench.sv */
// Self-checking testbench of the timed pin port unit.
`timescale 1ns/1ps
module testbench;
	logic        clk_i = 0, sys_rst_i = 1, psel_i = 0, penable_i = 0, pwrite_i = 0;
	logic [11:0] paddr_i = 0;
	logic [31:0] pwdata_i = 0, ext_val = 0, ext_en = 32'hFFFF_0000, prdata_o, pin_i, pin_o, pin_oe_o, pin_pd_o;
	logic        pready_o, pslverr_o;
	logic [4:0]  rdy = 0, ready_in_i, outgoing_strobe_o, port_event_o;
	logic [127:0] bus_q[$], pin_q[$];
	int          err_count = 0, n_tests = 0;
	always #20 clk_i = ~clk_i;
	tspp_port_unit DUT (.clk_i, .sys_rst_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i, .pready_o,
		.prdata_o, .pslverr_o, .pin_i, .pin_o, .pin_oe_o, .pin_pd_o, .ready_in_i, .outgoing_strobe_o,
		.port_event_o);
	tspp_pin_model PEER (.clk_i, .drv_i(pin_o), .drv_en_i(pin_oe_o), .pd_en_i(pin_pd_o), .ext_val_i(ext_val),
		.ext_en_i(ext_en), .rdy_i(rdy), .level_o(pin_i), .ready_o(ready_in_i));
	// ********************************
	// Tasks
	// ********************************
	task test_done;
		$display("comparisons %0d, mismatches %0d", n_tests, err_count);
		if (err_count == 0 && n_tests > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask
	task chk(input string nm, input logic [63:0] e, input logic [63:0] s, input logic [63:0] m);
		n_tests++;
		if ((s & m) !== (e & m)) begin
			err_count++;
			$display("unexpected %s: expected %h, seen %h", nm, e & m, s & m);
		end
	endtask
	// Only the watchdog ends a wait; an edge passes after each transfer before the next setup.
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		psel_i <= 1; penable_i <= 0; pwrite_i <= w; paddr_i <= a; pwdata_i <= d;
		@(posedge clk_i) penable_i <= 1;
		do @(posedge clk_i); while (pready_o !== 1'b1);
		psel_i <= 0; penable_i <= 0;
		@(posedge clk_i);
	endtask
	task rd(input logic [11:0] a, input logic [32:0] e, input logic [32:0] m);
		bus_q.push_back({31'h0, m, 31'h0, e});
		apb(0, a, 32'h0000_0000);
	endtask
	task wait_hit(input int port, input bit ev);
		while ((ev ? port_event_o[port] : outgoing_strobe_o[port]) !== 1'b1) @(posedge clk_i);
		@(posedge clk_i);
	endtask
	// Monitor: each bus read or output strobe takes the oldest expectation.
	always @(posedge clk_i) begin
		logic [127:0] x;
		if (psel_i && penable_i && pready_o && !pwrite_i && bus_q.size() > 0) begin
			x = bus_q.pop_front();
			chk("prdata", x[63:0], {31'h0, pslverr_o, prdata_o}, x[127:64]);
		end
		if (outgoing_strobe_o !== 5'h00 && pin_q.size() > 0) begin
			x = pin_q.pop_front();
			chk("pins", x[63:0], {pin_oe_o, pin_o}, x[127:64]);
		end
	end
	initial begin
		#800000;
		err_count++;
		test_done();
	end
	// ********************************
	// Scenarios
	// ********************************
	initial begin
		logic [31:0] d, e, r, f;
		void'($urandom(40));
		repeat (4) @(posedge clk_i);
		sys_rst_i <= 0;
		@(posedge clk_i);
		rd(12'h040, 33'h0, 33'h1_FFFF_FFFF);
		rd(12'h140, 33'h0, 33'h1_FFFF_FFFF);
		rd(12'h108, 33'h1_0000_0000, 33'h1_FFFF_FFFF);
		apb(1, 12'h144, 32'h0000_0003);
		rd(12'h144, 33'h3, 33'h1_FFFF_FFFF);
		apb(1, 12'h060, 32'h0000_00C3);
		d = $urandom;
		pin_q.push_back({64'hFFFF_FFFF_FFFF_FFFF, 32'h0000_FFFF, 16'h0, d[15:0]});
		apb(1, 12'h064, d);
		wait_hit(3, 0);
		apb(1, 12'h020, 32'h0000_0047);
		e = $urandom;
		pin_q.push_back({64'hFFFF_FFFF_FFFF_FFFF, 16'h0, 12'hFFF, ~e[3:0], 16'h0, d[15:4], 4'h0});
		apb(1, 12'h024, e);
		wait_hit(1, 0);
		r = $urandom;
		ext_val <= r;
		apb(1, 12'h080, 32'h0000_0001);
		wait_hit(4, 1);
		ext_val <= ~r;
		apb(1, 12'h100, 32'h0000_0001);
		rd(12'h100, 33'h1, 33'h1_FFFF_FFFF);
		rd(12'h084, {1'b0, r[31:16], 16'h0}, 33'h1_FFFF_0000);
		repeat (3) @(posedge clk_i);
		wait_hit(4, 1);
		rd(12'h084, {9'h0, ~r[23:16], 16'h0}, 33'h1_00FF_0000);
		// Port 4 turns to output with its clock stopped, so only the new word is sent.
		f = $urandom;
		apb(1, 12'h080, 32'h0000_0303);
		apb(1, 12'h084, f);
		pin_q.push_back({64'hFFFF_FFFF_FFFF_FFFF, 16'h00FF, 12'hFFF, ~e[3:0], 8'h00, f[23:16], d[15:4], 4'h0});
		apb(1, 12'h080, 32'h0000_0043);
		wait_hit(4, 0);
		// Port 0 waits for pin 0 equal to one and for its ready-in strobe.
		ext_val <= {~r[31:1], 1'b0};
		ext_en <= 32'hFFFF_0001;
		rdy <= 5'h01;
		apb(1, 12'h00C, 32'h0000_0001);
		apb(1, 12'h000, 32'h0000_0049);
		repeat (4) @(posedge clk_i);
		rd(12'h018, 33'h0, 33'h1_FFFF_FFFF);
		ext_val[0] <= 1'b1;
		rdy <= 5'h00;
		repeat (4) @(posedge clk_i);
		rd(12'h018, 33'h0, 33'h1_FFFF_FFFF);
		rdy <= 5'h01;
		repeat (4) @(posedge clk_i);
		rd(12'h018, 33'h1, 33'h1_FFFF_FFFF);
		rd(12'h004, 33'h1, 33'h1_FFFF_FFFF);
		repeat (4) @(posedge clk_i);
		chk("queues", 64'h0, 64'(bus_q.size() + pin_q.size()), '1);
		test_done();
	end
endmodule
